// file: rtl/perf_sel_pkg.sv
// constants, field layout and event table of the cache and tlb event selector
// assumes a 32-bit classic wishbone slave with byte addresses
package perf_sel_pkg;
	// register byte offsets
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFF_SELECT = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
	// select register fields
	localparam int SEL_CODE_LSB = 0;
	localparam int SEL_MASK_LSB = 8;
	localparam int SEL_EN_BIT = 16;
	localparam logic [31:0] SEL_USED = 32'h0001_ffff;
	// status register bits
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_LISTED_BIT = 1;
	localparam int STAT_HALT_BIT = 2;
	localparam int STAT_WALK_BIT = 3;
	localparam int STAT_HIT_BIT = 4;
	// values after reset
	localparam logic [31:0] RST_SELECT = 32'h0000_0000;
	localparam logic [31:0] RST_COUNT = 32'h0000_0000;
	localparam logic [31:0] RST_DATA = 32'h0000_0000;
	// event codes
	localparam logic [7:0] EV_L2_DATA = 8'h26;
	localparam logic [7:0] EV_OWN_WRITE = 8'h27;
	localparam logic [7:0] EV_L1_WB = 8'h28;
	localparam logic [7:0] EV_LLC = 8'h2e;
	localparam logic [7:0] EV_UNHALTED = 8'h3c;
	localparam logic [7:0] EV_DATA_TLB = 8'h49;
	// unit masks compared whole
	localparam logic [7:0] UM_LLC_MISS = 8'h41;
	localparam logic [7:0] UM_LLC_REF = 8'h4f;
	localparam logic [7:0] UM_CORE_CYC = 8'h00;
	localparam logic [7:0] UM_REF_CYC = 8'h01;
	// unit mask bits of the tlb event
	localparam int DT_WALK_START_BIT = 0;
	localparam int DT_WALK_DONE_BIT = 1;
	localparam int DT_WALK_CYC_BIT = 2;
	localparam int DT_SECOND_LEVEL_TLB_HIT_BIT = 4;
	localparam int DT_LOW_ADDR_BIT = 5;
	// cache line state, used as a bit index into a mask nibble
	typedef enum logic [1:0] {ST_I, ST_S, ST_E, ST_M} line_state_t;
	// one accepted code and mask pair
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] mask;
	} combo_t;
	localparam int NUM_COMBOS = 36;
	localparam combo_t COMBOS [NUM_COMBOS] = '{
		'{EV_L2_DATA, 8'h01}, '{EV_L2_DATA, 8'h02}, '{EV_L2_DATA, 8'h04}, '{EV_L2_DATA, 8'h08},
		'{EV_L2_DATA, 8'h0f}, '{EV_L2_DATA, 8'h10}, '{EV_L2_DATA, 8'h20}, '{EV_L2_DATA, 8'h40},
		'{EV_L2_DATA, 8'h80}, '{EV_L2_DATA, 8'hf0}, '{EV_L2_DATA, 8'hff},
		'{EV_OWN_WRITE, 8'h01}, '{EV_OWN_WRITE, 8'h02}, '{EV_OWN_WRITE, 8'h08}, '{EV_OWN_WRITE, 8'h0e},
		'{EV_OWN_WRITE, 8'h0f}, '{EV_OWN_WRITE, 8'h10}, '{EV_OWN_WRITE, 8'h20}, '{EV_OWN_WRITE, 8'h40},
		'{EV_OWN_WRITE, 8'h80}, '{EV_OWN_WRITE, 8'he0}, '{EV_OWN_WRITE, 8'hf0},
		'{EV_L1_WB, 8'h01}, '{EV_L1_WB, 8'h02}, '{EV_L1_WB, 8'h04}, '{EV_L1_WB, 8'h08}, '{EV_L1_WB, 8'h0f},
		'{EV_LLC, UM_LLC_MISS}, '{EV_LLC, UM_LLC_REF}, '{EV_UNHALTED, UM_CORE_CYC}, '{EV_UNHALTED, UM_REF_CYC},
		'{EV_DATA_TLB, 8'h01}, '{EV_DATA_TLB, 8'h02}, '{EV_DATA_TLB, 8'h04}, '{EV_DATA_TLB, 8'h10}, '{EV_DATA_TLB, 8'h20}
	};
endpackage

// file: rtl/sel_event_if.sv
// bundle between the selector top and its cache state matcher
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface sel_event_if;
	import perf_sel_pkg::*;
	logic [7:0] code;
	logic [7:0] umask;
	logic l2d_valid;
	logic l2d_prefetch;
	logic l2d_pf_own;
	line_state_t l2d_state;
	logic own_valid;
	logic own_lock;
	logic own_prefetch;
	line_state_t own_state;
	logic wb_valid;
	line_state_t wb_state;
	logic hit;
	modport owner (output code, umask, l2d_valid, l2d_prefetch, l2d_pf_own, l2d_state,
		own_valid, own_lock, own_prefetch, own_state, wb_valid, wb_state, input hit);
	modport matcher (input code, umask, l2d_valid, l2d_prefetch, l2d_pf_own, l2d_state,
		own_valid, own_lock, own_prefetch, own_state, wb_valid, wb_state, output hit);
endinterface

// file: rtl/cache_state_matcher.sv
// matches second-level lookups, ownership writes and writebacks against the mask
// assumes the owner gates the result with the accepted-combination check
`timescale 1ns/1ps
module cache_state_matcher
	import perf_sel_pkg::*;
(
	sel_event_if.matcher ev
);
	// one mask nibble holds one bit per line state
	function automatic logic nib_hit(input logic [3:0] nib, input line_state_t st);
		return nib[st];
	endfunction

	line_state_t eff_state;

	// an ownership prefetch cannot be served by a shared copy
	always_comb begin
		eff_state = ev.l2d_state;
		if (ev.l2d_prefetch && ev.l2d_pf_own && ev.l2d_state == ST_S) begin
			eff_state = ST_I; // [R2]
		end
	end

	// per-state bits are or-ed, so combined masks need no special case
	always_comb begin
		ev.hit = 1'b0;
		case (ev.code)
			EV_L2_DATA: begin
				if (ev.l2d_prefetch) begin
					ev.hit = ev.l2d_valid && nib_hit(ev.umask[7:4], eff_state); // [R1] [R18]
				end else begin
					ev.hit = ev.l2d_valid && nib_hit(ev.umask[3:0], eff_state); // [R3] [R18]
				end
			end
			EV_OWN_WRITE: begin
				if (ev.own_lock) begin
					ev.hit = ev.own_valid && nib_hit(ev.umask[7:4], ev.own_state); // [R7]
				end else begin
					// only demand stores count here
					ev.hit = ev.own_valid && !ev.own_prefetch && nib_hit(ev.umask[3:0], ev.own_state); // [R4] [R5] [R6]
				end
			end
			EV_L1_WB: begin
				ev.hit = ev.wb_valid && nib_hit(ev.umask[3:0], ev.wb_state); // [R8]
			end
			default: begin
				ev.hit = 1'b0;
			end
		endcase
	end
endmodule

// file: rtl/cache_tlb_event_selector.sv
// cache and tlb event selector with one 32-bit event counter
// assumes event inputs come from logic on clk_sys, a classic wishbone master,
// and at most one occurrence per cycle for the selected code
//
// What this block does
// [R1] code 26H, masks 20H 40H 80H count prefetch hits by state; F0H all prefetches.
// [R2] a prefetch ownership request on a shared line counts as miss, prefetch read as hit.
// [R3] code 26H mask FFH counts every second-level data request, demand and prefetch.
// [R4] code 27H masks 01H 02H 08H count demand store ownership by invalid, shared, modified.
// [R5] code 27H mask 0EH counts store ownership hits; 0FH counts all of them.
// [R6] store ownership requests counted under 27H masks 01H-0FH are demand only, never prefetch; locked masks 10H-F0H also count prefetches.
// [R7] code 27H masks 10H-80H count locked requests by state; E0H hits, F0H all.
// [R8] code 28H counts first-level writebacks by target state; 0FH counts all.
// [R9] code 2EH counts last-level misses with 41H and references with 4FH.
// [R10] code 3CH mask 00H counts every clock cycle the thread is not halted.
// [R11] code 3CH mask 01H counts timestamp reference ticks while not halted.
// [R12] code 49H mask 01H counts second-level tlb misses that start a page walk.
// [R13] code 49H mask 02H counts second-level tlb misses whose walk completed.
// [R14] code 49H mask 04H counts every cycle spent in a page walk.
// [R15] code 49H mask 10H counts first-level tlb misses hitting second-level tlb.
// [R16] code 49H mask 20H counts misses due to the low address part, 2M pages included.
// [R17] only listed code and mask pairs count; any other pair leaves the counter alone.
// [R18] per-state mask bits within one code are or-ed together.
`timescale 1ns/1ps
module cache_tlb_event_selector
	import perf_sel_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// second-level data lookups
	input wire logic l2d_valid,
	input wire logic l2d_prefetch,
	input wire logic l2d_pf_own,
	input wire logic [1:0] l2d_state,
	// second-level ownership writes
	input wire logic own_valid,
	input wire logic own_lock,
	input wire logic own_prefetch,
	input wire logic [1:0] own_state,
	// first-level writebacks
	input wire logic wb_line_valid,
	input wire logic [1:0] wb_line_state,
	// last-level cache
	input wire logic llc_ref,
	input wire logic llc_miss,
	// thread clock state
	input wire logic thread_halted,
	input wire logic ref_tick,
	// data translation
	input wire logic walk_start,
	input wire logic walk_done,
	input wire logic walk_active,
	input wire logic second_level_tlb_hit,
	input wire logic low_addr_miss
);
	// accepted pair lookup, shared by the counting and status paths
	function automatic logic combo_listed(input logic [7:0] code, input logic [7:0] mask);
		logic found;
		found = 1'b0;
		for (int i = 0; i < NUM_COMBOS; i++) begin
			if (COMBOS[i].code == code && COMBOS[i].mask == mask) begin
				found = 1'b1;
			end
		end
		return found;
	endfunction

	// byte-lane merge for wishbone writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [31:0] select_ff;
	logic [31:0] count_ff;
	logic ovf_ff;
	logic last_hit_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [7:0] sel_code;
	logic [7:0] sel_mask;
	logic sel_en;
	logic listed;
	logic other_hit;
	logic count_inc;
	logic bus_req;
	logic wr_select;
	logic wr_count;
	logic wr_status;
	logic [31:0] nxt_count;
	logic [31:0] rd_mux;

	sel_event_if ev_bus();

	// select register fields
	assign sel_code = select_ff[SEL_CODE_LSB +: 8];
	assign sel_mask = select_ff[SEL_MASK_LSB +: 8];
	assign sel_en = select_ff[SEL_EN_BIT];

	// hand the cache state events to the matcher
	assign ev_bus.code = sel_code;
	assign ev_bus.umask = sel_mask;
	assign ev_bus.l2d_valid = l2d_valid;
	assign ev_bus.l2d_prefetch = l2d_prefetch;
	assign ev_bus.l2d_pf_own = l2d_pf_own;
	assign ev_bus.l2d_state = line_state_t'(l2d_state);
	assign ev_bus.own_valid = own_valid;
	assign ev_bus.own_lock = own_lock;
	assign ev_bus.own_prefetch = own_prefetch;
	assign ev_bus.own_state = line_state_t'(own_state);
	assign ev_bus.wb_valid = wb_line_valid;
	assign ev_bus.wb_state = line_state_t'(wb_line_state);

	cache_state_matcher u_matcher (
		.ev(ev_bus.matcher)
	);

	// unlisted pairs never count, even if some mask bit would match
	assign listed = combo_listed(sel_code, sel_mask); // [R17]

	// events decoded here: last-level cache, cycles and translation
	always_comb begin
		other_hit = 1'b0;
		case (sel_code)
			EV_LLC: begin
				if (sel_mask == UM_LLC_MISS) begin
					other_hit = llc_miss; // [R9]
				end else if (sel_mask == UM_LLC_REF) begin
					other_hit = llc_ref; // [R9]
				end
			end
			EV_UNHALTED: begin
				if (sel_mask == UM_CORE_CYC) begin
					// every clk_sys edge is a thread cycle here
					other_hit = !thread_halted; // [R10]
				end else if (sel_mask == UM_REF_CYC) begin
					// reference ticks stop with the thread, like the core cycles
					other_hit = ref_tick && !thread_halted; // [R11]
				end
			end
			EV_DATA_TLB: begin
				other_hit = (sel_mask[DT_WALK_START_BIT] && walk_start) // [R12]
					|| (sel_mask[DT_WALK_DONE_BIT] && walk_done) // [R13]
					|| (sel_mask[DT_WALK_CYC_BIT] && walk_active) // [R14]
					|| (sel_mask[DT_SECOND_LEVEL_TLB_HIT_BIT] && second_level_tlb_hit) // [R15]
					|| (sel_mask[DT_LOW_ADDR_BIT] && low_addr_miss); // [R16]
			end
			default: begin
				other_hit = 1'b0;
			end
		endcase
	end

	// one occurrence per cycle; the two paths never match the same code
	assign count_inc = sel_en && listed && (ev_bus.hit || other_hit); // [R17] [R18]

	// bus decode: one request per cycle, answered on the next edge
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wr_select = bus_req && wb_we_i && wb_adr_i == OFF_SELECT;
	assign wr_count = bus_req && wb_we_i && wb_adr_i == OFF_COUNT;
	assign wr_status = bus_req && wb_we_i && wb_adr_i == OFF_STATUS;

	// a software load wins over a same-cycle event, so the loaded value is exact
	always_comb begin
		nxt_count = count_ff;
		if (wr_count) begin
			nxt_count = lane_merge(count_ff, wb_dat_i, wb_sel_i);
		end else if (count_inc) begin
			nxt_count = count_ff + 32'h0000_0001;
		end
	end

	// read data mux; unmapped offsets read as zero
	always_comb begin
		rd_mux = RST_DATA;
		case (wb_adr_i)
			OFF_SELECT: begin
				rd_mux = select_ff;
			end
			OFF_COUNT: begin
				rd_mux = count_ff;
			end
			OFF_STATUS: begin
				rd_mux[STAT_OVF_BIT] = ovf_ff;
				rd_mux[STAT_LISTED_BIT] = listed;
				rd_mux[STAT_HALT_BIT] = thread_halted;
				rd_mux[STAT_WALK_BIT] = walk_active;
				rd_mux[STAT_HIT_BIT] = last_hit_ff;
			end
			default: begin
				rd_mux = RST_DATA;
			end
		endcase
	end

	// select register; unused bits are kept at zero
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			select_ff <= RST_SELECT;
		end else if (wr_select) begin
			select_ff <= lane_merge(select_ff, wb_dat_i, wb_sel_i) & SEL_USED;
		end
	end

	// event counter; wraps through zero and flags it
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			count_ff <= RST_COUNT;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// sticky wrap flag, write one to clear; a wrap in the clearing cycle wins
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ovf_ff <= 1'b0;
		end else if (!wr_count && count_inc && count_ff == '1) begin
			ovf_ff <= 1'b1;
		end else if (wr_status && wb_sel_i[0] && wb_dat_i[STAT_OVF_BIT]) begin
			ovf_ff <= 1'b0;
		end
	end

	// last cycle's count decision, for software polling
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			last_hit_ff <= 1'b0;
		end else begin
			last_hit_ff <= count_inc;
		end
	end

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_req;
		end
	end

	// read data captured with a read request, held until the next read
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rdata_ff <= RST_DATA;
		end else if (bus_req && !wb_we_i) begin
			rdata_ff <= rd_mux;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
endmodule

// file: tb/event_source_model.sv
// stand-in for the cache hierarchy and tlb event sources
// assumes fire() is called just after a rising edge of clk_sys
`timescale 1ns/1ps
module event_source_model
(
	input wire logic clk_sys,
	output logic [10:0] pulse,
	output logic pf,
	output logic pf_own,
	output logic lock,
	output logic [1:0] st
);
	initial begin
		pulse = 11'h000;
		{pf, pf_own, lock, st} = 5'h00;
	end
	// one-cycle event; the state flips once released so a stale value never matches
	task automatic fire(input int k, input logic [1:0] s, input logic a, input logic b);
		pulse[k] <= 1'b1;
		st <= s;
		pf <= a; // a prefetch store ownership is only sent when a case asks for it
		pf_own <= b;
		lock <= b;
		@(posedge clk_sys);
		pulse <= 11'h000;
		st <= ~s;
		@(posedge clk_sys);
	endtask
endmodule

// file: tb/cache_tlb_event_selector_assertions.sv
// bus and status checks on the selector's top-level ports
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module cache_tlb_event_selector_assertions
	import perf_sel_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic thread_halted,
	input wire logic walk_active
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// a request is taken only while ack is low
	logic take;
	logic rd;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd = take && !wb_we_i;
	AST_ACK_NEXT: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	AST_DAT_HOLD: assert property (!$past(rd) |-> $stable(wb_dat_o))
		else $error("read data moved without a read");
	AST_UNMAPPED: assert property (rd && wb_adr_i == 4'hc |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_SEL_UNUSED: assert property (rd && wb_adr_i == OFF_SELECT |=> (wb_dat_o & ~SEL_USED) == 32'h0000_0000)
		else $error("unused select bits read back");
	AST_STAT_HALT: assert property (rd && wb_adr_i == OFF_STATUS && $stable(thread_halted) |=>
		wb_dat_o[STAT_HALT_BIT] == $past(thread_halted)) else $error("halt status wrong");
	AST_STAT_WALK: assert property (rd && wb_adr_i == OFF_STATUS && $stable(walk_active) |=>
		wb_dat_o[STAT_WALK_BIT] == $past(walk_active)) else $error("walk status wrong");
	AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn |=> !wb_ack_o && wb_dat_o == RST_DATA)
		else $error("outputs busy in reset");
endmodule
bind cache_tlb_event_selector cache_tlb_event_selector_assertions chk (.clk_sys(clk_sys), .resetn(resetn),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .thread_halted(thread_halted), .walk_active(walk_active));

// file: tb/cache_tlb_event_selector_test.sv
// self-checking bench for the event selector
// assumes the event source model drives every event input except thread_halted, which the bench drives itself
`timescale 1ns/1ps
module cache_tlb_event_selector_test
	import perf_sel_pkg::*;
;
	logic clk_sys, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, thread_halted, pf, pf_own, lock;
	logic [ADDR_W-1:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, c1;
	logic [10:0] p;
	logic [1:0] st;
	int error_cnt, n_tests, cyc_n;
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	event_source_model src (.clk_sys, .pulse(p), .pf, .pf_own, .lock, .st);
	cache_tlb_event_selector dut (.clk_sys, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .l2d_valid(p[0]), .l2d_prefetch(pf), .l2d_pf_own(pf_own), .l2d_state(st),
		.own_valid(p[1]), .own_lock(lock), .own_prefetch(pf), .own_state(st), .wb_line_valid(p[2]),
		.wb_line_state(st), .llc_ref(p[3]), .llc_miss(p[4]), .thread_halted, .ref_tick(p[5]),
		.walk_start(p[6]), .walk_done(p[7]), .walk_active(p[10]), .second_level_tlb_hit(p[8]), .low_addr_miss(p[9]));
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// hang guard, about nineteen times the some 425 cycles the tests need
	always @(posedge clk_sys) begin
		cyc_n++;
		if (cyc_n == 8000) begin
			error_cnt++;
			final_report;
		end
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	// one classic cycle; request held until ack is sampled, then released for a cycle
	// no wait limit here: only the hang guard ends a missing answer
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
		do begin
			@(posedge clk_sys);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_sys);
	endtask
	// select a pair, clear, raise one event, read back the count
	task automatic t(input logic [7:0] c, input logic [7:0] m, input int k, input logic [1:0] s,
		input logic a, input logic b, input logic [31:0] e);
		bus(1'b1, OFF_SELECT, {15'h0000, 1'b1, m, c}, q);
		bus(1'b1, OFF_COUNT, 32'h0000_0000, q);
		src.fire(k, s, a, b);
		bus(1'b0, OFF_COUNT, 32'h0000_0000, q);
		chk($sformatf("count %h/%h", c, m), e, q);
	endtask
	initial begin
		{resetn, wb_cyc_i, wb_stb_i, wb_we_i, thread_halted} = 5'h00;
		{wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		bus(1'b0, OFF_SELECT, 32'h0000_0000, q);
		chk("select reset", RST_SELECT, q);
		bus(1'b1, OFF_SELECT, 32'hffff_ffff, q);
		bus(1'b0, OFF_SELECT, 32'h0000_0000, q);
		chk("select unused bits", SEL_USED, q);
		bus(1'b0, OFF_STATUS, 32'h0000_0000, q);
		chk("unlisted pair", 32'h0000_0000, {31'h0, q[STAT_LISTED_BIT]});
		bus(1'b1, 4'hc, 32'h5a5a_5a5a, q);
		bus(1'b0, 4'hc, 32'h0000_0000, q);
		chk("unmapped read", 32'h0000_0000, q);
		$display("test registers done");
		t(8'h26, 8'h20, 0, 2'd1, 1'b1, 1'b0, 1);
		t(8'h26, 8'h40, 0, 2'd2, 1'b1, 1'b0, 1);
		t(8'h26, 8'h80, 0, 2'd3, 1'b1, 1'b0, 1);
		t(8'h26, 8'hf0, 0, 2'd0, 1'b1, 1'b0, 1);
		t(8'h26, 8'h40, 0, 2'd2, 1'b0, 1'b0, 0);
		t(8'h26, 8'h20, 0, 2'd1, 1'b1, 1'b1, 0);
		t(8'h26, 8'h10, 0, 2'd1, 1'b1, 1'b1, 1);
		t(8'h26, 8'hff, 0, 2'd2, 1'b0, 1'b0, 1);
		t(8'h27, 8'h01, 1, 2'd0, 1'b0, 1'b0, 1);
		t(8'h27, 8'h02, 1, 2'd1, 1'b0, 1'b0, 1);
		t(8'h27, 8'h08, 1, 2'd3, 1'b0, 1'b1, 0);
		t(8'h27, 8'h0e, 1, 2'd2, 1'b0, 1'b0, 1);
		t(8'h27, 8'h0e, 1, 2'd0, 1'b0, 1'b0, 0);
		t(8'h27, 8'h0f, 1, 2'd1, 1'b1, 1'b0, 0);
		t(8'h27, 8'h40, 1, 2'd2, 1'b0, 1'b1, 1);
		t(8'h27, 8'he0, 1, 2'd0, 1'b0, 1'b1, 0);
		t(8'h27, 8'hf0, 1, 2'd0, 1'b0, 1'b1, 1);
		t(8'h28, 8'h04, 2, 2'd2, 1'b0, 1'b0, 1);
		t(8'h28, 8'h02, 2, 2'd3, 1'b0, 1'b0, 0);
		t(8'h2e, 8'h41, 4, 2'd0, 1'b0, 1'b0, 1);
		t(8'h2e, 8'h41, 3, 2'd0, 1'b0, 1'b0, 0);
		t(8'h2e, 8'h4f, 3, 2'd0, 1'b0, 1'b0, 1);
		t(8'h3c, 8'h01, 5, 2'd0, 1'b0, 1'b0, 1);
		t(8'h49, 8'h01, 6, 2'd0, 1'b0, 1'b0, 1);
		t(8'h49, 8'h02, 7, 2'd0, 1'b0, 1'b0, 1);
		t(8'h49, 8'h02, 6, 2'd0, 1'b0, 1'b0, 0);
		t(8'h49, 8'h04, 10, 2'd0, 1'b0, 1'b0, 1);
		t(8'h49, 8'h10, 8, 2'd0, 1'b0, 1'b0, 1);
		t(8'h49, 8'h20, 9, 2'd0, 1'b0, 1'b0, 1);
		t(8'h27, 8'h04, 1, 2'd2, 1'b0, 1'b0, 0);
		// mask bit 0 alone would count this walk start, so only the pair check stops it
		t(8'h49, 8'h03, 6, 2'd0, 1'b0, 1'b0, 0);
		$display("test event codes done");
		// halted thread: neither cycles nor reference ticks advance the count
		thread_halted <= 1'b1;
		t(8'h3c, 8'h01, 5, 2'd0, 1'b0, 1'b0, 0);
		bus(1'b1, OFF_COUNT, 32'h0000_0000, q);
		bus(1'b1, OFF_SELECT, {15'h0000, 1'b1, UM_CORE_CYC, EV_UNHALTED}, q);
		bus(1'b0, OFF_COUNT, 32'h0000_0000, q);
		chk("halted cycles", 32'h0000_0000, q);
		bus(1'b0, OFF_STATUS, 32'h0000_0000, q);
		chk("halt flag", 32'h0000_0001, {31'h0, q[STAT_HALT_BIT]});
		chk("listed pair", 32'h0000_0001, {31'h0, q[STAT_LISTED_BIT]});
		chk("no count while halted", 32'h0000_0000, {31'h0, q[STAT_HIT_BIT]});
		thread_halted <= 1'b0;
		// two reads three cycles apart see three unhalted cycles
		bus(1'b0, OFF_COUNT, 32'h0000_0000, c1);
		bus(1'b0, OFF_COUNT, 32'h0000_0000, q);
		chk("unhalted cycles", 32'h0000_0003, q - c1);
		bus(1'b0, OFF_STATUS, 32'h0000_0000, q);
		chk("counted last cycle", 32'h0000_0001, {31'h0, q[STAT_HIT_BIT]});
		$display("test halt done");
		// reset in mid-run while the counter is busy: select and count go back
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		bus(1'b0, OFF_COUNT, 32'h0000_0000, q);
		chk("count after reset", RST_COUNT, q);
		bus(1'b0, OFF_SELECT, 32'h0000_0000, q);
		chk("select after reset", RST_SELECT, q);
		$display("test reset done");
		// wrap of the counter sets the sticky flag, cleared by writing one
		bus(1'b1, OFF_SELECT, {15'h0000, 1'b1, 8'h0f, EV_L1_WB}, q);
		bus(1'b1, OFF_COUNT, 32'hffff_ffff, q);
		src.fire(2, 2'd0, 1'b0, 1'b0);
		bus(1'b0, OFF_COUNT, 32'h0000_0000, q);
		chk("wrapped count", 32'h0000_0000, q);
		bus(1'b0, OFF_STATUS, 32'h0000_0000, q);
		chk("wrap flag", 32'h0000_0001, {31'h0, q[STAT_OVF_BIT]});
		bus(1'b1, OFF_STATUS, 32'h0000_0001, q);
		bus(1'b0, OFF_STATUS, 32'h0000_0000, q);
		chk("wrap flag cleared", 32'h0000_0000, {31'h0, q[STAT_OVF_BIT]});
		$display("test wrap done");
		final_report;
	end
endmodule
